// [fir_cfg.svh]
`ifndef FIR_CFG_SVH
`define FIR_CFG_SVH
// ****************************************
// clock and suspend latency
// ****************************************
`define FIR_CLK_MHZ        200
`define FIR_PSL_NS         20000
`define FIR_ESL_NS         20000
`define FIR_PSL_CYC        ((`FIR_PSL_NS * `FIR_CLK_MHZ + 999) / 1000)
`define FIR_ESL_CYC        ((`FIR_ESL_NS * `FIR_CLK_MHZ + 999) / 1000)
// ****************************************
// status word field positions and reset value
// ****************************************
`define FIR_ST_WIP         0
`define FIR_ST_WEL         1
`define FIR_ST_SUS         15
`define FIR_ST_RESET       16'h0000
// ****************************************
// opcodes
// ****************************************
`define FIR_OP_ID_READ     8'h9F
`define FIR_OP_SUSPEND     8'h75
`define FIR_OP_RESUME      8'h7A
`define FIR_OP_WRITE_ENABLE_COMMAND        8'h06
`define FIR_OP_WRITE_DISABLE_COMMAND        8'h04
`define FIR_OP_PP          8'h02
`define FIR_OP_QPP         8'h32
// ****************************************
// identification bytes, values are arbitrary
// ****************************************
`define FIR_MFR_ID         8'hA5
`define FIR_DEV_ID         16'h5A3C
// ****************************************
// region masks for the suspended operation
// ****************************************
`define FIR_MASK_PAGE      24'hFFFF00
`define FIR_MASK_4K        24'hFFF000
`define FIR_MASK_32K       24'hFF8000
`define FIR_MASK_64K       24'hFF0000
`endif

// [fir_pkg.sv]
package fir_pkg;
	// link-side command phases
	typedef enum logic [1:0] {
		FIR_IDLE,
		FIR_OPCODE,
		FIR_ID_OUT,
		FIR_IGNORE
	} fir_link_t;
	// suspend state of the array operation
	typedef enum logic [1:0] {
		FIR_RUN,
		FIR_PENDING,
		FIR_PSUSP,
		FIR_ESUSP
	} fir_sus_t;
	// kind of array operation in progress
	typedef enum logic [1:0] {
		FIR_OP_PAGE,
		FIR_OP_SECT4K,
		FIR_OP_BLK32K,
		FIR_OP_BLK64K
	} fir_op_t;
endpackage : fir_pkg

// [fir_top.sv]
`timescale 1ns/1ps
`include "fir_cfg.svh"
module fir_top #(
	parameter int PSL_CYC   = `FIR_PSL_CYC,
	parameter int ESL_CYC   = `FIR_ESL_CYC,
	parameter int BUF_DEPTH = 2,
	parameter int BUF_WIDTH = 8
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_clk_en,
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic        i_si,
	input  wire logic        i_op_active,
	input  wire logic [1:0]  i_op_type,
	input  wire logic [23:0] i_op_addr,
	input  wire logic        i_op_done,
	input  wire logic [23:0] i_rd_addr,
	output logic             o_so,
	output logic             o_so_oe,
	output logic             o_cmd_valid,
	output logic [7:0]       o_cmd_code,
	output logic             o_suspend_req,
	output logic             o_resume_req,
	output logic [15:0]      o_status,
	output logic             o_rd_permit
);
	// ****************************************
	// elaboration checks
	// ****************************************
	initial begin
		if (BUF_DEPTH < 2 || BUF_WIDTH != 8 || PSL_CYC < 1 || ESL_CYC < 1 || PSL_CYC > 65535 || ESL_CYC > 65535)
			$error("fir_top: unsupported parameter value");
	end

	localparam int PW = $clog2(BUF_DEPTH);

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	logic [2:0] sclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] si_sync_reg;
	// the third sclk stage only serves edge detection on a settled value
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg   <= 2'h3;
			si_sync_reg   <= 2'h0;
		end else if (i_clk_en) begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
			cs_sync_reg   <= {cs_sync_reg[0], i_cs_n};
			si_sync_reg   <= {si_sync_reg[0], i_si};
		end
	end
	wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	wire cs_idle   = cs_sync_reg[1];
	wire si_bit    = si_sync_reg[1];

	// ****************************************
	// opcode capture
	// ****************************************
	fir_pkg::fir_link_t link_reg;
	logic [6:0]         shift_reg;
	logic [2:0]         bit_cnt_reg;
	logic               dec_stb_reg;
	logic [7:0]         dec_op_reg;
	logic               id_go;
	// deselect always wins and parks the link in standby
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			link_reg    <= fir_pkg::FIR_IDLE;
			shift_reg   <= 7'h00;
			bit_cnt_reg <= 3'h0;
			dec_stb_reg <= 1'b0;
			dec_op_reg  <= 8'h00;
		end else if (i_clk_en) begin
			dec_stb_reg <= 1'b0;
			if (cs_idle) begin
				link_reg    <= fir_pkg::FIR_IDLE;
				bit_cnt_reg <= 3'h0;
			end else begin
				case (link_reg)
					fir_pkg::FIR_IDLE: begin
						link_reg <= fir_pkg::FIR_OPCODE;
					end
					fir_pkg::FIR_OPCODE: begin
						if (sclk_rise) begin
							shift_reg   <= {shift_reg[5:0], si_bit};
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
							if (bit_cnt_reg == 3'h7) begin
								dec_stb_reg <= 1'b1;
								dec_op_reg  <= {shift_reg, si_bit};
								link_reg    <= fir_pkg::FIR_IGNORE;
							end
						end
					end
					fir_pkg::FIR_IGNORE: begin
						if (id_go)
							link_reg <= fir_pkg::FIR_ID_OUT;
					end
					default: begin
						link_reg <= link_reg;
					end
				endcase
			end
		end
	end

	// ****************************************
	// command acceptance during suspend
	// ****************************************
	fir_pkg::fir_sus_t sus_reg;
	logic              nested_reg;

	function automatic logic fir_accept(input logic [7:0] op, input fir_pkg::fir_sus_t s, input logic busy);
		logic nolat;
		logic both;
		logic erase_only;
		nolat      = 1'b0;
		both       = 1'b0;
		erase_only = 1'b0;
		case (op)
			8'h05, 8'h35, 8'h15, 8'hAB, 8'h66, 8'h99, 8'h00, 8'h48: nolat = 1'b1;
			8'h03, 8'h0B, 8'h0D, 8'h3B, 8'h6B, 8'hBB, 8'hBD, 8'hEB,
			8'hE7, 8'hED, 8'h0C, 8'h0E: both = 1'b1;
			8'h38, 8'hFF, 8'h5A, 8'h9F, 8'h90, 8'h92, 8'h94, 8'h77,
			8'hC0, 8'h7A, 8'h3D, 8'h04: both = 1'b1;
			8'h06, 8'h02, 8'h32, 8'h42, 8'h39, 8'h98: erase_only = 1'b1;
			default: begin
				nolat = 1'b0;
			end
		endcase
		case (s)
			fir_pkg::FIR_RUN:     fir_accept = !(busy && op == `FIR_OP_ID_READ);
			fir_pkg::FIR_PENDING: fir_accept = nolat;
			fir_pkg::FIR_PSUSP:   fir_accept = nolat | both;
			fir_pkg::FIR_ESUSP:   fir_accept = nolat | both | erase_only;
			default:              fir_accept = 1'b0;
		endcase
	endfunction

	wire cmd_ok = dec_stb_reg & fir_accept(dec_op_reg, sus_reg, i_op_active);
	// resume is refused while a nested page program still runs
	wire resume_ok = cmd_ok & (dec_op_reg == `FIR_OP_RESUME) & ~nested_reg
	               & (sus_reg == fir_pkg::FIR_PSUSP || sus_reg == fir_pkg::FIR_ESUSP);
	wire suspend_ok = dec_stb_reg & (dec_op_reg == `FIR_OP_SUSPEND) & i_op_active
	                & (sus_reg == fir_pkg::FIR_RUN) & ~nested_reg;
	wire pp_nested = cmd_ok & (sus_reg == fir_pkg::FIR_ESUSP) & o_status[`FIR_ST_WEL]
	               & (dec_op_reg == `FIR_OP_PP || dec_op_reg == `FIR_OP_QPP);
	assign id_go = cmd_ok & (dec_op_reg == `FIR_OP_ID_READ);

	// ****************************************
	// suspend state and latency
	// ****************************************
	logic [15:0]        lat_cnt_reg;
	fir_pkg::fir_op_t   sus_type_reg;
	logic [23:0]        sus_addr_reg;
	wire                lat_end = (sus_reg == fir_pkg::FIR_PENDING) && (lat_cnt_reg == 16'h0001);
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sus_reg      <= fir_pkg::FIR_RUN;
			lat_cnt_reg  <= 16'h0000;
			sus_type_reg <= fir_pkg::FIR_OP_PAGE;
			sus_addr_reg <= 24'h000000;
			nested_reg   <= 1'b0;
		end else if (i_clk_en) begin
			case (sus_reg)
				fir_pkg::FIR_RUN: begin
					if (suspend_ok) begin
						sus_reg      <= fir_pkg::FIR_PENDING;
						sus_type_reg <= fir_pkg::fir_op_t'(i_op_type);
						sus_addr_reg <= i_op_addr;
						lat_cnt_reg  <= (i_op_type == 2'h0) ? PSL_CYC[15:0] : ESL_CYC[15:0];
					end
				end
				fir_pkg::FIR_PENDING: begin
					lat_cnt_reg <= lat_cnt_reg - 16'h0001;
					if (lat_end)
						sus_reg <= (sus_type_reg == fir_pkg::FIR_OP_PAGE) ? fir_pkg::FIR_PSUSP : fir_pkg::FIR_ESUSP;
				end
				default: begin
					if (resume_ok)
						sus_reg <= fir_pkg::FIR_RUN;
				end
			endcase
			// nested program ends only on its own completion
			if (pp_nested)
				nested_reg <= 1'b1;
			else if (i_op_done)
				nested_reg <= 1'b0;
		end
	end

	// ****************************************
	// status word and command outputs
	// ****************************************
	logic wel_set;
	logic wel_clr;
	always_comb begin
		wel_set = resume_ok | (cmd_ok & dec_op_reg == `FIR_OP_WRITE_ENABLE_COMMAND);
		wel_clr = lat_end | (cmd_ok & dec_op_reg == `FIR_OP_WRITE_DISABLE_COMMAND) | i_op_done;
	end
	// set beats clear when both land in one cycle, except that i_op_done clears WIP over the running-op set
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_status      <= `FIR_ST_RESET;
			o_cmd_valid   <= 1'b0;
			o_cmd_code    <= 8'h00;
			o_suspend_req <= 1'b0;
			o_resume_req  <= 1'b0;
		end else if (i_clk_en) begin
			if (wel_set)
				o_status[`FIR_ST_WEL] <= 1'b1;
			else if (wel_clr)
				o_status[`FIR_ST_WEL] <= 1'b0;
			if (resume_ok || pp_nested)
				o_status[`FIR_ST_WIP] <= 1'b1;
			else if (i_op_done || lat_end)
				o_status[`FIR_ST_WIP] <= 1'b0;
			else if (sus_reg == fir_pkg::FIR_RUN && i_op_active)
				o_status[`FIR_ST_WIP] <= 1'b1;
			if (lat_end)
				o_status[`FIR_ST_SUS] <= 1'b1;
			else if (resume_ok)
				o_status[`FIR_ST_SUS] <= 1'b0;
			o_cmd_valid   <= cmd_ok & ~id_go;
			o_cmd_code    <= dec_op_reg;
			o_suspend_req <= suspend_ok;
			o_resume_req  <= resume_ok;
		end
	end

	// ****************************************
	// read region guard
	// ****************************************
	logic [23:0] reg_mask;
	always_comb begin
		case (sus_type_reg)
			fir_pkg::FIR_OP_PAGE:   reg_mask = `FIR_MASK_PAGE;
			fir_pkg::FIR_OP_SECT4K: reg_mask = `FIR_MASK_4K;
			fir_pkg::FIR_OP_BLK32K: reg_mask = `FIR_MASK_32K;
			default:                reg_mask = `FIR_MASK_64K;
		endcase
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_rd_permit <= 1'b1;
		else if (i_clk_en)
			o_rd_permit <= !(o_status[`FIR_ST_SUS] && ((i_rd_addr & reg_mask) == (sus_addr_reg & reg_mask)));
	end

	// ****************************************
	// id byte source into two-entry buffer
	// ****************************************
	logic [1:0]           id_idx_reg;
	logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
	logic [PW-1:0]        wr_ptr_reg;
	logic [PW-1:0]        rd_ptr_reg;
	logic [PW:0]          cnt_reg;
	logic [BUF_WIDTH-1:0] id_byte;
	wire                  in_id   = (link_reg == fir_pkg::FIR_ID_OUT) && !cs_idle;
	wire                  buf_rdy = (cnt_reg != BUF_DEPTH[PW:0]);
	wire                  buf_val = (cnt_reg != '0);
	wire                  push    = in_id && (id_idx_reg != 2'h3) && buf_rdy;
	logic [2:0]           out_bit_reg;
	wire                  pop     = in_id && sclk_fall && (out_bit_reg == 3'h0) && buf_val;
	always_comb begin
		case (id_idx_reg)
			2'h0:    id_byte = `FIR_MFR_ID;
			2'h1:    id_byte = 8'(`FIR_DEV_ID >> 8);
			default: id_byte = 8'(`FIR_DEV_ID & 16'h00FF);
		endcase
	end
	// the source stalls on a full buffer; a deselect flushes it
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			id_idx_reg <= 2'h0;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else if (i_clk_en) begin
			if (!in_id) begin
				id_idx_reg <= 2'h0;
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
				cnt_reg    <= '0;
			end else begin
				if (push) begin
					id_idx_reg <= id_idx_reg + 2'h1;
					wr_ptr_reg <= (wr_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
				end
				if (pop)
					rd_ptr_reg <= (rd_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
				cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
			end
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_clk_en && push)
			buf_mem[wr_ptr_reg] <= id_byte;
	end

	// ****************************************
	// serial output shifter
	// ****************************************
	logic [6:0] out_sh_reg;
	// bits change on falling sclk, msb first; deselect may cut it anywhere
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_so        <= 1'b0;
			o_so_oe     <= 1'b0;
			out_sh_reg  <= 7'h00;
			out_bit_reg <= 3'h0;
		end else if (i_clk_en) begin
			if (!in_id) begin
				o_so_oe     <= 1'b0;
				out_bit_reg <= 3'h0;
			end else if (sclk_fall) begin
				o_so_oe <= 1'b1;
				if (out_bit_reg == 3'h0) begin
					o_so       <= buf_val ? buf_mem[rd_ptr_reg][7] : 1'b0;
					out_sh_reg <= buf_val ? buf_mem[rd_ptr_reg][6:0] : 7'h00;
				end else begin
					o_so       <= out_sh_reg[6];
					out_sh_reg <= {out_sh_reg[5:0], 1'b0};
				end
				out_bit_reg <= out_bit_reg + 3'h1;
			end
		end
	end
endmodule : fir_top

// [fir_top_asserts.sv]
`timescale 1ns/1ps
// ****************************************
// port checker for the id read and suspend gate
// ****************************************
module fir_top_asserts #(
	parameter int PSL_CYC = 20,
	parameter int ESL_CYC = 20
) (
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	input wire logic        i_cs_n,
	input wire logic        o_so_oe,
	input wire logic        o_cmd_valid,
	input wire logic [7:0]  o_cmd_code,
	input wire logic        o_suspend_req,
	input wire logic        o_resume_req,
	input wire logic [15:0] o_status,
	input wire logic        o_rd_permit
);
	localparam int MAXL = (PSL_CYC > ESL_CYC) ? PSL_CYC : ESL_CYC;
	localparam int MINL = (PSL_CYC < ESL_CYC) ? PSL_CYC : ESL_CYC;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	int lat_cnt_reg;
	// latency is a parameter, so a counter instead of a long repetition
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) lat_cnt_reg <= 0;
		else if (o_suspend_req) lat_cnt_reg <= 1;
		else if (o_status[15]) lat_cnt_reg <= 0;
		else if (lat_cnt_reg != 0) lat_cnt_reg <= lat_cnt_reg + 1;
	end
	a_sus_latency_bound: assert property (lat_cnt_reg <= MAXL + 4)
		else $error("suspend flag late");
	a_sus_rise_clean: assert property ($rose(o_status[15]) |->
		o_status[1:0] == 2'b00 && lat_cnt_reg >= MINL - 4) else $error("suspend flag set wrongly");
	a_early_set_only: assert property (o_cmd_valid && lat_cnt_reg != 0 |->
		o_cmd_code inside {8'h05, 8'h35, 8'h15, 8'hAB, 8'h66, 8'h99, 8'h00, 8'h48}) else $error("early command");
	a_lock_refused: assert property (o_cmd_valid && o_status[15] |->
		!(o_cmd_code inside {8'h44, 8'h36, 8'h7E})) else $error("lock command in suspend");
	a_resume_flags: assert property (o_resume_req |-> o_status[1:0] == 2'b11 && !o_status[15])
		else $error("resume flags wrong");
	a_oe_deselect: assert property (i_cs_n [*6] |-> !o_so_oe)
		else $error("output driven while deselected");
	a_id_when_busy: assert property (o_so_oe |-> !o_status[0] || o_status[15])
		else $error("id read while busy");
	a_permit_running: assert property (!o_status[15] [*2] |-> o_rd_permit)
		else $error("read blocked while running");
	a_suspend_fresh: assert property (o_suspend_req |-> !o_resume_req && !o_status[15])
		else $error("suspend while suspended");
	c_suspend: cover property ($rose(o_status[15]));
	c_resume: cover property (o_resume_req);
	c_blocked: cover property (!o_rd_permit);
endmodule : fir_top_asserts

bind fir_top fir_top_asserts #(.PSL_CYC(PSL_CYC), .ESL_CYC(ESL_CYC)) fir_top_asserts_inst (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .o_so_oe(o_so_oe),
	.o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code), .o_suspend_req(o_suspend_req),
	.o_resume_req(o_resume_req), .o_status(o_status), .o_rd_permit(o_rd_permit));

// [fir_host_model.sv]
`timescale 1ns/1ps
// ****************************************
// serial host, mode 0, sclk of 25 system cycles
// ****************************************
module fir_host_model (
	input  wire logic i_sys_clk,
	input  wire logic i_so,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_si
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_si   = 1'b0;
	end
	// sclk stands low between frames; si toggles once released
	task automatic frame(input logic [7:0] op, input int nrd, output logic [23:0] rd);
		rd = 24'h000000;
		@(posedge i_sys_clk);
		o_cs_n <= 1'b0;
		for (int b = 0; b < 8 + nrd; b++) begin
			o_si <= (b < 8) ? op[7 - b] : ~o_si;
			repeat (12) @(posedge i_sys_clk);
			o_sclk <= 1'b1;
			if (b >= 8) rd = {rd[22:0], i_so};
			repeat (13) @(posedge i_sys_clk);
			o_sclk <= 1'b0;
		end
		repeat (12) @(posedge i_sys_clk);
		o_cs_n <= 1'b1;
		o_si   <= ~o_si;
		repeat (30) @(posedge i_sys_clk);
	endtask : frame
endmodule : fir_host_model

// [fir_top_test.sv]
`timescale 1ns/1ps
`include "fir_cfg.svh"
// ****************************************
// bench: id read and suspend command gating
// ****************************************
module fir_top_test;
	localparam int LAT = 2000; // outlasts the refused 32-bit id frame plus two short frames
	logic        i_sys_clk, i_reset_n, i_cs_n, i_sclk, i_si, i_op_active, i_op_done;
	logic [1:0]  i_op_type;
	logic [23:0] i_op_addr, i_rd_addr, rd;
	logic        o_so, o_so_oe, o_cmd_valid, o_suspend_req, o_resume_req, o_rd_permit;
	logic [7:0]  o_cmd_code, last_code;
	logic [15:0] o_status;
	int          failures = 0, checked = 0, n_cmd = 0, n_sus = 0, n_res = 0, n_oe = 0, c0;
	initial i_sys_clk = 1'b0;
	always #2.5 i_sys_clk = ~i_sys_clk;
	fir_top #(.PSL_CYC(LAT), .ESL_CYC(LAT)) fir_top_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_clk_en(1'b1), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_si(i_si), .i_op_active(i_op_active),
		.i_op_type(i_op_type), .i_op_addr(i_op_addr), .i_op_done(i_op_done), .i_rd_addr(i_rd_addr),
		.o_so(o_so), .o_so_oe(o_so_oe), .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code),
		.o_suspend_req(o_suspend_req), .o_resume_req(o_resume_req), .o_status(o_status),
		.o_rd_permit(o_rd_permit));
	fir_host_model fir_host_model_inst (.i_sys_clk(i_sys_clk), .i_so(o_so), .o_cs_n(i_cs_n),
		.o_sclk(i_sclk), .o_si(i_si));
	// one-cycle pulses are counted here, tasks compare the counts after each frame
	always @(posedge i_sys_clk) begin
		n_cmd <= n_cmd + int'(o_cmd_valid === 1'b1);
		n_sus <= n_sus + int'(o_suspend_req === 1'b1);
		n_res <= n_res + int'(o_resume_req === 1'b1);
		n_oe  <= n_oe + int'(o_so_oe === 1'b1);
		if (o_cmd_valid === 1'b1) last_code <= o_cmd_code;
	end
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// send one opcode and see whether it was forwarded
	task automatic cmd(input logic [7:0] op, input logic acc);
		c0 = n_cmd;
		fir_host_model_inst.frame(op, 0, rd);
		check("forwarded", {23'h0, acc}, 24'(n_cmd - c0));
		if (acc) check("code", {16'h0, op}, {16'h0, last_code});
	endtask : cmd
	task automatic stat(input logic [15:0] exp);
		check("status", {8'h0, exp}, {8'h0, o_status});
	endtask : stat
	task automatic permit(input logic [23:0] a, input logic exp);
		i_rd_addr <= a;
		repeat (3) @(posedge i_sys_clk);
		check("read permit", {23'h0, exp}, {23'h0, o_rd_permit});
	endtask : permit
	task automatic resume(input logic [23:0] exp_n, input logic [15:0] exp_st);
		c0 = n_res;
		fir_host_model_inst.frame(`FIR_OP_RESUME, 0, rd);
		check("resume pulse", exp_n, 24'(n_res - c0));
		stat(exp_st);
	endtask : resume
	task automatic end_op(input logic keep);
		i_op_done   <= 1'b1;
		i_op_active <= keep;
		@(posedge i_sys_clk);
		i_op_done <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
	endtask : end_op
	task automatic suspend(input logic [1:0] typ, input logic [23:0] a);
		i_op_type   <= typ;
		i_op_addr   <= a;
		i_op_active <= 1'b1;
		repeat (40) @(posedge i_sys_clk);
		c0 = n_sus;
		fir_host_model_inst.frame(`FIR_OP_SUSPEND, 0, rd);
		check("suspend pulse", 24'h1, 24'(n_sus - c0));
	endtask : suspend
	task automatic t_id_read;
		stat(16'h0000);
		fir_host_model_inst.frame(`FIR_OP_ID_READ, 24, rd);
		check("id bytes", {`FIR_MFR_ID, `FIR_DEV_ID}, rd);
		fir_host_model_inst.frame(`FIR_OP_ID_READ, 11, rd);
		check("cut id", {13'h0, `FIR_MFR_ID, 3'(`FIR_DEV_ID >> 13)}, rd);
		check("oe after cut", 24'h0, {23'h0, o_so_oe});
		fir_host_model_inst.frame(`FIR_OP_ID_READ, 24, rd);
		check("id again", {`FIR_MFR_ID, `FIR_DEV_ID}, rd);
		$display("t_id_read done");
	endtask : t_id_read
	task automatic t_erase_suspend;
		suspend(2'h1, 24'h012345);
		c0 = n_oe;
		fir_host_model_inst.frame(`FIR_OP_ID_READ, 24, rd);
		check("oe while busy", 24'h0, 24'(n_oe - c0));
		cmd(8'h05, 1'b1);
		cmd(8'h03, 1'b0);
		repeat (LAT) @(posedge i_sys_clk);
		stat(16'h8000);
		permit(24'h012FFF, 1'b0);
		permit(24'h013000, 1'b1);
		fir_host_model_inst.frame(`FIR_OP_ID_READ, 24, rd);
		check("id in suspend", {`FIR_MFR_ID, `FIR_DEV_ID}, rd);
		cmd(8'h03, 1'b1);
		cmd(8'h44, 1'b0);
		cmd(8'h06, 1'b1);
		cmd(8'h02, 1'b1);
		stat(16'h8003);
		resume(24'h0, 16'h8003);
		end_op(1'b1);
		stat(16'h8000);
		resume(24'h1, 16'h0003);
		end_op(1'b0);
		$display("t_erase_suspend done");
	endtask : t_erase_suspend
	task automatic t_prog_suspend;
		suspend(2'h0, 24'h0401A0);
		repeat (LAT) @(posedge i_sys_clk);
		stat(16'h8000);
		cmd(8'h06, 1'b0);
		cmd(8'h32, 1'b0);
		cmd(8'h39, 1'b0);
		cmd(8'h7E, 1'b0);
		cmd(8'h04, 1'b1);
		cmd(8'hEB, 1'b1);
		permit(24'h0401FF, 1'b0);
		permit(24'h040200, 1'b1);
		resume(24'h1, 16'h0003);
		end_op(1'b0);
		$display("t_prog_suspend done");
	endtask : t_prog_suspend
	task automatic give_verdict;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	// watchdog, several times the expected run length
	initial begin
		#400000;
		failures++;
		give_verdict;
	end
	initial begin
		i_reset_n   = 1'b0;
		i_op_active = 1'b0;
		i_op_done   = 1'b0;
		i_op_type   = 2'h0;
		i_op_addr   = 24'h000000;
		i_rd_addr   = 24'h000000;
		repeat (8) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		t_id_read;
		t_erase_suspend;
		t_prog_suspend;
		give_verdict;
	end
endmodule : fir_top_test
